/* File: shared/hqmac_defines.svh */
// Offsets, field positions, reset values and timing counts for the queue MAC control block
`ifndef HQMAC_DEFINES_SVH
`define HQMAC_DEFINES_SVH
// Register indexes; byte address is four times the index
`define HQMAC_IDX_TX_CTRL      6'h00
`define HQMAC_IDX_TX_STAT      6'h02
`define HQMAC_IDX_RX_CTRL      6'h04
`define HQMAC_IDX_BUS_CFG      6'h08
`define HQMAC_ADR_TX_CTRL      8'h00
`define HQMAC_ADR_TX_STAT      8'h08
`define HQMAC_ADR_RX_CTRL      8'h10
`define HQMAC_ADR_BUS_CFG      8'h20
// transmit_control fields
`define HQMAC_TX_RUN_BIT       0
`define HQMAC_TX_CRC_BIT       1
`define HQMAC_TX_PAD_BIT       2
`define HQMAC_TX_PAUSE_BIT     3
`define HQMAC_TX_CTRL_MASK     16'h000F
// receive_control fields
`define HQMAC_RX_RUN_BIT       0
`define HQMAC_RX_HASH_BIT      2
`define HQMAC_RX_STRIP_BIT     3
`define HQMAC_RX_PROM_BIT      4
`define HQMAC_RX_UCAST_BIT     5
`define HQMAC_RX_MCAST_BIT     6
`define HQMAC_RX_BCAST_BIT     7
`define HQMAC_RX_BADCRC_BIT    9
`define HQMAC_RX_PAUSE_BIT     10
`define HQMAC_RX_CTRL_MASK     16'h06FD
// Reset values
`define HQMAC_TX_CTRL_RST      16'h0000
`define HQMAC_RX_CTRL_RST      16'h0000
`define HQMAC_BUS_CFG_RST      1'b0
// Frame figures
`define HQMAC_MIN_FRAME_BYTES  11'h040
`define HQMAC_FRAME_ID_MSB     5
`define HQMAC_BUS_CFG_BIT      0
// One pause quantum is 512 bit times at 100 Mb/s
`define HQMAC_PAUSE_QUANTUM_NS 5120
`define HQMAC_CLK_PERIOD_NS    40
`define HQMAC_QUANTUM_CYCLES   ((`HQMAC_PAUSE_QUANTUM_NS + `HQMAC_CLK_PERIOD_NS - 1) / `HQMAC_CLK_PERIOD_NS)
`endif

/* File: shared/hqmac_pkg.sv */
// Types shared by the queue MAC control block
package hqmac_pkg;
  typedef enum logic [1:0] {
    HQMAC_TX_IDLE  = 2'b00,
    HQMAC_TX_SEND  = 2'b01
  } hqmac_tx_state_e;
  typedef enum logic [1:0] {
    HQMAC_RX_IDLE  = 2'b00,
    HQMAC_RX_FRAME = 2'b01
  } hqmac_rx_state_e;
  typedef struct packed {
    logic [5:0]  id;
    logic [10:0] len;
  } hqmac_tx_req_s;
  typedef struct packed {
    logic [47:0] dest;
    logic        crc_err;
    logic        hash_hit;
  } hqmac_rx_hdr_s;
  typedef struct packed {
    logic        pad;
    logic        crc;
    logic [5:0]  id;
  } hqmac_tx_attr_s;
endpackage

/* File: core/hqmac_ctrl.sv */
// Control and status of the host queue MAC: registers, transmit gating, receive filtering
//
// The implementer's own choice: the Wishbone interface to the registers.
`include "hqmac_defines.svh"

module hqmac_ctrl
  import hqmac_pkg::*;
(
  input  wire logic          clk_i,
  input  wire logic          rst_i,
  // Wishbone classic slave
  input  wire logic          wb_cyc_i,
  input  wire logic          wb_stb_i,
  input  wire logic          wb_we_i,
  input  wire logic [7:0]    wb_adr_i,
  input  wire logic [3:0]    wb_sel_i,
  input  wire logic [31:0]   wb_dat_i,
  output logic      [31:0]   wb_dat_o,
  output logic               wb_ack_o,
  // Serial memory configuration load
  input  wire logic          serial_mem_enable_pin_i,
  input  wire logic          cfg_word_valid_i,
  input  wire logic [15:0]   cfg_word_i,
  // Transmit side
  input  wire logic          tx_req_valid_i,
  input  wire hqmac_tx_req_s tx_req_i,
  output logic               tx_req_ready_o,
  output logic               tx_start_o,
  output hqmac_tx_attr_s     tx_attr_o,
  input  wire logic          tx_done_i,
  output logic               tx_busy_o,
  // Flow control
  input  wire logic          switch_global_ctrl_three_fc_i,
  input  wire logic          rx_fifo_thresh_i,
  output logic               pause_send_o,
  input  wire logic          rx_pause_valid_i,
  input  wire logic [15:0]   rx_pause_quanta_i,
  output logic               tx_paused_o,
  // Receive side, then the bus width strap output
  input  wire logic [47:0]   station_addr_i,
  input  wire logic          rx_hdr_valid_i,
  input  wire hqmac_rx_hdr_s rx_hdr_i,
  input  wire logic          rx_end_i,
  output logic               rx_accept_o,
  output logic               rx_discard_o,
  output logic               rx_strip_crc_o,
  output logic               rx_busy_o,
  output logic               host_bus_16bit_o
);

  localparam logic [6:0] QUANTUM_LAST = 7'(`HQMAC_QUANTUM_CYCLES - 1);

  logic [15:0]      transmit_control;
  logic [15:0]      receive_control;
  logic [5:0]       last_tx_frame_id;
  logic             bus_width_config;
  hqmac_tx_state_e  tx_state;
  hqmac_rx_state_e  rx_state;
  logic [15:0]      pause_quanta;
  logic [6:0]       pause_sub;
  logic             wr_stb;
  logic             rx_match;
  logic             rx_is_mcast;
  logic             rx_is_bcast;
  logic             tx_go;

  wire tx_run_en            = transmit_control[`HQMAC_TX_RUN_BIT];
  wire tx_crc_append_en     = transmit_control[`HQMAC_TX_CRC_BIT];
  wire tx_pad_en            = transmit_control[`HQMAC_TX_PAD_BIT];
  wire tx_pause_generate_en = transmit_control[`HQMAC_TX_PAUSE_BIT];
  wire rx_run_en            = receive_control[`HQMAC_RX_RUN_BIT];
  wire rx_mhash_en          = receive_control[`HQMAC_RX_HASH_BIT];
  wire rx_crc_strip_en      = receive_control[`HQMAC_RX_STRIP_BIT];
  wire rx_promiscuous_en    = receive_control[`HQMAC_RX_PROM_BIT];
  wire rx_ucast_accept_en   = receive_control[`HQMAC_RX_UCAST_BIT];
  wire rx_mcast_accept_en   = receive_control[`HQMAC_RX_MCAST_BIT];
  wire rx_bcast_accept_en   = receive_control[`HQMAC_RX_BCAST_BIT];
  wire rx_bad_crc_admit_en  = receive_control[`HQMAC_RX_BADCRC_BIT];
  wire rx_pause_honour_en   = receive_control[`HQMAC_RX_PAUSE_BIT];

  // Bus slave: one wait state, ack drops the cycle after it is given
  // Writes land on the edge that samples ack, the one edge master and slave share
  assign wr_stb = wb_cyc_i & wb_stb_i & wb_we_i & wb_ack_o;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= wb_cyc_i & wb_stb_i & ~wb_ack_o;
    end
  end

  // Byte lanes 0 and 1 carry the 16-bit registers
  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d, input logic [3:0] sel);
    merge16 = {sel[1] ? d[15:8] : old[15:8], sel[0] ? d[7:0] : old[7:0]};
  endfunction

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      transmit_control <= `HQMAC_TX_CTRL_RST;
    end else if (wr_stb && wb_adr_i == `HQMAC_ADR_TX_CTRL) begin
      transmit_control <= merge16(transmit_control, wb_dat_i, wb_sel_i) & `HQMAC_TX_CTRL_MASK;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      receive_control <= `HQMAC_RX_CTRL_RST;
    end else if (wr_stb && wb_adr_i == `HQMAC_ADR_RX_CTRL) begin
      receive_control <= merge16(receive_control, wb_dat_i, wb_sel_i) & `HQMAC_RX_CTRL_MASK;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_dat_o <= 32'h00000000;
    end else if (wb_cyc_i && wb_stb_i && !wb_we_i && !wb_ack_o) begin
      if (wb_adr_i == `HQMAC_ADR_TX_CTRL) begin
        wb_dat_o <= {16'h0000, transmit_control};
      end else if (wb_adr_i == `HQMAC_ADR_TX_STAT) begin
        wb_dat_o <= {26'h0000000, last_tx_frame_id};
      end else if (wb_adr_i == `HQMAC_ADR_RX_CTRL) begin
        wb_dat_o <= {16'h0000, receive_control};
      end else if (wb_adr_i == `HQMAC_ADR_BUS_CFG) begin
        wb_dat_o <= {31'h00000000, bus_width_config};
      end else begin
        // Unmapped addresses read zero
        wb_dat_o <= 32'h00000000;
      end
    end
  end

  // Bus width strap only follows the serial memory when it is fitted
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      bus_width_config <= `HQMAC_BUS_CFG_RST;
    end else if (serial_mem_enable_pin_i && cfg_word_valid_i) begin
      bus_width_config <= cfg_word_i[`HQMAC_BUS_CFG_BIT];
    end
  end
  assign host_bus_16bit_o = bus_width_config;

  // Pause honour timer: quanta counted down in whole 512-bit-time slots
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pause_quanta <= 16'h0000;
      pause_sub    <= 7'h00;
    end else if (rx_pause_valid_i && rx_pause_honour_en) begin
      pause_quanta <= rx_pause_quanta_i;
      pause_sub    <= QUANTUM_LAST;
    end else if (pause_quanta != 16'h0000) begin
      if (pause_sub == 7'h00) begin
        pause_quanta <= pause_quanta - 16'h0001;
        pause_sub    <= QUANTUM_LAST;
      end else begin
        pause_sub <= pause_sub - 7'h01;
      end
    end
  end
  assign tx_paused_o = (pause_quanta != 16'h0000);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pause_send_o <= 1'b0;
    end else begin
      pause_send_o <= tx_pause_generate_en & switch_global_ctrl_three_fc_i & rx_fifo_thresh_i;
    end
  end

  // Transmit: a frame in flight always finishes, stop acts between frames
  assign tx_go          = tx_run_en && !tx_paused_o && tx_state == HQMAC_TX_IDLE;
  assign tx_req_ready_o = tx_go;
  assign tx_busy_o      = (tx_state == HQMAC_TX_SEND);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tx_state <= HQMAC_TX_IDLE;
    end else begin
      case (tx_state)
        HQMAC_TX_IDLE: begin
          if (tx_go && tx_req_valid_i) begin
            tx_state <= HQMAC_TX_SEND;
          end
        end
        HQMAC_TX_SEND: begin
          if (tx_done_i) begin
            tx_state <= HQMAC_TX_IDLE;
          end
        end
        default: begin
          tx_state <= HQMAC_TX_IDLE;
        end
      endcase
    end
  end

  // Attributes frozen at start so a mid-frame register write cannot split a frame
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tx_start_o <= 1'b0;
      tx_attr_o  <= '0;
    end else begin
      tx_start_o <= tx_go && tx_req_valid_i;
      if (tx_go && tx_req_valid_i) begin
        tx_attr_o.id  <= tx_req_i.id;
        tx_attr_o.crc <= tx_crc_append_en;
        tx_attr_o.pad <= tx_pad_en && (tx_req_i.len < `HQMAC_MIN_FRAME_BYTES);
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      last_tx_frame_id <= 6'h00;
    end else if (tx_state == HQMAC_TX_SEND && tx_done_i) begin
      last_tx_frame_id <= tx_attr_o.id;
    end
  end

  // Receive address filter
  assign rx_is_bcast = (rx_hdr_i.dest == 48'hFFFFFFFFFFFF);
  assign rx_is_mcast = rx_hdr_i.dest[40];
  always_comb begin
    rx_match = 1'b0;
    if (rx_promiscuous_en) begin
      rx_match = 1'b1;
    end else if (rx_bcast_accept_en && rx_is_bcast) begin
      rx_match = 1'b1;
    end else if (rx_mcast_accept_en && rx_is_mcast) begin
      rx_match = 1'b1;
    end else if (rx_mhash_en && rx_is_mcast && !rx_is_bcast && rx_hdr_i.hash_hit) begin
      rx_match = 1'b1;
    end else if (rx_ucast_accept_en && !rx_is_mcast && rx_hdr_i.dest == station_addr_i) begin
      rx_match = 1'b1;
    end
  end

  assign rx_busy_o = (rx_state == HQMAC_RX_FRAME);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rx_state <= HQMAC_RX_IDLE;
    end else begin
      case (rx_state)
        HQMAC_RX_IDLE: begin
          if (rx_hdr_valid_i && rx_run_en) begin
            rx_state <= HQMAC_RX_FRAME;
          end
        end
        HQMAC_RX_FRAME: begin
          if (rx_end_i) begin
            rx_state <= HQMAC_RX_IDLE;
          end
        end
        default: begin
          rx_state <= HQMAC_RX_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rx_accept_o    <= 1'b0;
      rx_discard_o   <= 1'b0;
      rx_strip_crc_o <= 1'b0;
    end else begin
      rx_accept_o  <= 1'b0;
      rx_discard_o <= 1'b0;
      if (rx_hdr_valid_i && rx_run_en && rx_state == HQMAC_RX_IDLE) begin
        rx_accept_o    <= rx_match && (!rx_hdr_i.crc_err || rx_bad_crc_admit_en);
        rx_discard_o   <= !(rx_match && (!rx_hdr_i.crc_err || rx_bad_crc_admit_en));
        rx_strip_crc_o <= rx_crc_strip_en;
      end
    end
  end

  a_bus_cfg_load: assert property (@(posedge clk_i) disable iff (rst_i)
    serial_mem_enable_pin_i && cfg_word_valid_i |=> host_bus_16bit_o == $past(cfg_word_i[0]))
    else $error("bus width bit not loaded");
  a_bus_cfg_hold: assert property (@(posedge clk_i) disable iff (rst_i)
    !serial_mem_enable_pin_i |=> $stable(host_bus_16bit_o))
    else $error("bus width bit moved without serial memory");
  a_pause_send: assert property (@(posedge clk_i) disable iff (rst_i)
    pause_send_o == ($past(tx_pause_generate_en) && $past(switch_global_ctrl_three_fc_i) && $past(rx_fifo_thresh_i)))
    else $error("pause send mismatch");
  a_pad_short: assert property (@(posedge clk_i) disable iff (rst_i)
    tx_go && tx_req_valid_i |=> tx_attr_o.pad == ($past(tx_pad_en) && $past(tx_req_i.len) < 11'd64))
    else $error("padding decision wrong");
  a_crc_attr: assert property (@(posedge clk_i) disable iff (rst_i)
    tx_start_o |-> tx_attr_o.crc == $past(tx_crc_append_en))
    else $error("crc append attribute wrong");
  a_tx_finish: assert property (@(posedge clk_i) disable iff (rst_i)
    tx_busy_o && !tx_done_i |=> tx_busy_o)
    else $error("transmit frame cut short");
  a_tx_stopped: assert property (@(posedge clk_i) disable iff (rst_i)
    !tx_run_en |-> !tx_req_ready_o ##1 !tx_start_o)
    else $error("frame started while stopped");
  a_last_id: assert property (@(posedge clk_i) disable iff (rst_i)
    tx_busy_o && tx_done_i |=> last_tx_frame_id == $past(tx_attr_o.id))
    else $error("last frame id not recorded");
  a_pause_hold: assert property (@(posedge clk_i) disable iff (rst_i)
    rx_pause_valid_i && rx_pause_honour_en && rx_pause_quanta_i != 16'h0000 |=> !tx_req_ready_o [*8])
    else $error("transmit not held by pause");
  a_pause_ignore: assert property (@(posedge clk_i) disable iff (rst_i)
    !rx_pause_honour_en && !tx_paused_o |=> !tx_paused_o)
    else $error("pause taken while disabled");
  a_bad_crc_drop: assert property (@(posedge clk_i) disable iff (rst_i)
    rx_hdr_valid_i && rx_run_en && !rx_busy_o && rx_hdr_i.crc_err && !rx_bad_crc_admit_en |=> rx_discard_o)
    else $error("bad crc frame admitted");
  a_rx_promisc: assert property (@(posedge clk_i) disable iff (rst_i)
    rx_hdr_valid_i && rx_run_en && !rx_busy_o && rx_promiscuous_en && !rx_hdr_i.crc_err |=> rx_accept_o)
    else $error("promiscuous frame rejected");
  a_rx_bcast: assert property (@(posedge clk_i) disable iff (rst_i)
    rx_hdr_valid_i && rx_run_en && !rx_busy_o && rx_is_bcast && !rx_hdr_i.crc_err
      && (rx_bcast_accept_en || rx_mcast_accept_en) |=> rx_accept_o)
    else $error("broadcast frame rejected");
  a_rx_stop_frame: assert property (@(posedge clk_i) disable iff (rst_i)
    rx_busy_o && !rx_end_i |=> rx_busy_o)
    else $error("receive frame cut short");
  a_rx_none: assert property (@(posedge clk_i) disable iff (rst_i)
    (rx_accept_o || rx_discard_o) |-> !(rx_accept_o && rx_discard_o))
    else $error("frame both accepted and discarded");
  a_wb_ack_drop: assert property (@(posedge clk_i) disable iff (rst_i)
    wb_ack_o |=> !wb_ack_o)
    else $error("ack held two cycles");
  a_rx_ucast_hit: assert property (@(posedge clk_i) disable iff (rst_i)
    rx_hdr_valid_i && rx_run_en && !rx_busy_o && rx_ucast_accept_en && !rx_hdr_i.crc_err
      && !rx_hdr_i.dest[40] && rx_hdr_i.dest == station_addr_i |=> rx_accept_o)
    else $error("station address frame rejected");
  a_rx_mcast_all: assert property (@(posedge clk_i) disable iff (rst_i)
    rx_hdr_valid_i && rx_run_en && !rx_busy_o && rx_mcast_accept_en && rx_hdr_i.dest[40]
      && !rx_hdr_i.crc_err |=> rx_accept_o)
    else $error("multicast frame rejected");
  a_rx_hash_hit: assert property (@(posedge clk_i) disable iff (rst_i)
    rx_hdr_valid_i && rx_run_en && !rx_busy_o && rx_mhash_en && rx_hdr_i.dest[40] && rx_hdr_i.hash_hit
      && rx_hdr_i.dest != 48'hFFFFFFFFFFFF && !rx_hdr_i.crc_err |=> rx_accept_o)
    else $error("hash filtered frame rejected");
  a_rx_no_enable: assert property (@(posedge clk_i) disable iff (rst_i)
    rx_hdr_valid_i && rx_run_en && !rx_busy_o && !rx_promiscuous_en && !rx_bcast_accept_en
      && !rx_mcast_accept_en && !rx_mhash_en && !rx_ucast_accept_en |=> rx_discard_o && !rx_accept_o)
    else $error("frame accepted with no criterion enabled");
  a_rx_strip: assert property (@(posedge clk_i) disable iff (rst_i)
    rx_hdr_valid_i && rx_run_en && !rx_busy_o |=> rx_strip_crc_o == $past(rx_crc_strip_en))
    else $error("strip setting not latched");
  a_rx_stopped: assert property (@(posedge clk_i) disable iff (rst_i)
    !rx_run_en && !rx_busy_o |=> !rx_busy_o && !rx_accept_o && !rx_discard_o)
    else $error("frame taken while receive stopped");
  a_tx_start_pulse: assert property (@(posedge clk_i) disable iff (rst_i)
    tx_start_o |-> tx_busy_o ##1 !tx_start_o)
    else $error("start pulse malformed");
  a_pause_zero: assert property (@(posedge clk_i) disable iff (rst_i)
    rx_pause_valid_i && rx_pause_honour_en && rx_pause_quanta_i == 16'h0000 |=> !tx_paused_o)
    else $error("zero pause did not release");
  a_pause_gen_off: assert property (@(posedge clk_i) disable iff (rst_i)
    !switch_global_ctrl_three_fc_i || !tx_pause_generate_en |=> !pause_send_o)
    else $error("pause sent while disabled");
  a_stat_read: assert property (@(posedge clk_i) disable iff (rst_i)
    wb_ack_o && !wb_we_i && wb_adr_i == `HQMAC_ADR_TX_STAT
      |-> wb_dat_o == {26'h0000000, $past(last_tx_frame_id)})
    else $error("status read wrong");
  a_bus_cfg_read: assert property (@(posedge clk_i) disable iff (rst_i)
    wb_ack_o && !wb_we_i && wb_adr_i == `HQMAC_ADR_BUS_CFG
      |-> wb_dat_o == {31'h00000000, $past(host_bus_16bit_o)})
    else $error("bus width read wrong");
  a_ctrl_write: assert property (@(posedge clk_i) disable iff (rst_i)
    wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o && wb_adr_i == `HQMAC_ADR_TX_CTRL && wb_sel_i[0]
      |=> transmit_control[3:0] == $past(wb_dat_i[3:0]))
    else $error("transmit control write lost");

endmodule

/* File: verif/hqmac_tx_far.sv */
// Frame engine model: finishes each started frame after a chosen delay
module hqmac_tx_far (
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic       start_i,
  input  wire logic [7:0] lat_i,
  output logic            done_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] cnt;
  logic       act;
  // Delay set per frame so the bench can answer promptly or slowly
  always_ff @(posedge clk_i) begin
    done_o <= 1'b0;
    if (rst_i) begin
      act <= 1'b0;
      cnt <= 8'h00;
    end else if (start_i) begin
      act <= 1'b1;
      cnt <= lat_i;
    end else if (act) begin
      if (cnt == 8'h00) begin
        act    <= 1'b0;
        done_o <= 1'b1;
      end else begin
        cnt <= cnt - 8'h01;
      end
    end
  end
endmodule

/* File: verif/tb.sv */
// Register bus, transmit, flow control and receive filter tests
`include "hqmac_defines.svh"
module tb
  import hqmac_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, serial_mem_enable_pin_i, cfg_word_valid_i;
  logic [7:0] wb_adr_i, lat;
  logic [3:0] wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o;
  logic [15:0] cfg_word_i, rx_pause_quanta_i;
  logic tx_req_valid_i, tx_req_ready_o, tx_start_o, tx_done_i, tx_busy_o, pause_send_o;
  logic switch_global_ctrl_three_fc_i, rx_fifo_thresh_i, rx_pause_valid_i, tx_paused_o;
  logic rx_hdr_valid_i, rx_end_i, rx_accept_o, rx_discard_o, rx_strip_crc_o, rx_busy_o;
  logic host_bus_16bit_o, wb_ack_o;
  logic [47:0] station_addr_i;
  hqmac_tx_req_s tx_req_i;
  hqmac_rx_hdr_s rx_hdr_i;
  hqmac_tx_attr_s tx_attr_o;
  int error_cnt, samples_checked;
  localparam logic [47:0] STA = 48'h0A0B0C0D0E0F;
  localparam logic [47:0] OTH = 48'h0A0B0C0D0E10;
  localparam logic [47:0] MC = 48'h01005E000001;
  localparam logic [47:0] BC = 48'hFFFFFFFFFFFF;

  hqmac_ctrl uut (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i,
    .wb_dat_o, .wb_ack_o, .serial_mem_enable_pin_i, .cfg_word_valid_i, .cfg_word_i, .tx_req_valid_i,
    .tx_req_i, .tx_req_ready_o, .tx_start_o, .tx_attr_o, .tx_done_i, .tx_busy_o,
    .switch_global_ctrl_three_fc_i, .rx_fifo_thresh_i, .pause_send_o, .rx_pause_valid_i,
    .rx_pause_quanta_i, .tx_paused_o, .station_addr_i, .rx_hdr_valid_i, .rx_hdr_i, .rx_end_i,
    .rx_accept_o, .rx_discard_o, .rx_strip_crc_o, .rx_busy_o, .host_bus_16bit_o);
  hqmac_tx_far far (.clk_i, .rst_i, .start_i(tx_start_o), .lat_i(lat), .done_o(tx_done_i));

  task automatic close_out();
    if (error_cnt == 0 && samples_checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  // Holds the request until the edge that samples ack
  task automatic wb_xfer(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    int n;
    n = 0;
    wb_cyc_i <= 1'b1; wb_stb_i <= 1'b1; wb_we_i <= w; wb_adr_i <= a; wb_dat_i <= d; wb_sel_i <= 4'h3;
    do begin @(posedge clk_i); n++; end while (wb_ack_o !== 1'b1 && n < 50);
    q = wb_dat_o;
    if (n >= 50) error_cnt++;
    wb_cyc_i <= 1'b0; wb_stb_i <= 1'b0; wb_we_i <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic wb_wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    wb_xfer(1'b1, a, d, q);
  endtask
  task automatic wb_rd(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] q;
    wb_xfer(1'b0, a, 32'h0, q);
    chk(q, e);
  endtask
  task automatic wait_idle();
    int n;
    n = 0;
    while (tx_busy_o !== 1'b0 && n < 300) begin @(posedge clk_i); n++; end
    if (n >= 300) error_cnt++;
    tick(1);
  endtask
  task automatic tx_send(input logic [5:0] id, input logic [10:0] len, input logic [7:0] exp);
    int n;
    n = 0;
    tx_req_valid_i <= 1'b1;
    tx_req_i <= '{id: id, len: len};
    do begin @(posedge clk_i); n++; end while (tx_req_ready_o !== 1'b1 && n < 100);
    tx_req_valid_i <= 1'b0;
    @(posedge clk_i);
    chk(tx_start_o, 1);
    chk(tx_attr_o, exp);
  endtask
  task automatic rx_case(input logic [15:0] c, input logic [47:0] d, input logic e, h, a);
    wb_wr(`HQMAC_ADR_RX_CTRL, c);
    rx_hdr_valid_i <= 1'b1;
    rx_hdr_i <= '{dest: d, crc_err: e, hash_hit: h};
    @(posedge clk_i);
    rx_hdr_valid_i <= 1'b0;
    @(posedge clk_i);
    chk({rx_accept_o, rx_discard_o}, {a, c[0] & ~a});
    if (c[0]) chk(rx_strip_crc_o, c[3]);
    rx_end_i <= 1'b1;
    @(posedge clk_i);
    rx_end_i <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic pause_pulse(input logic [15:0] qn);
    rx_pause_valid_i <= 1'b1; rx_pause_quanta_i <= qn;
    @(posedge clk_i);
    rx_pause_valid_i <= 1'b0;
  endtask

  initial begin
    clk_i = 1'b0;
    forever #20 clk_i = ~clk_i;
  end
  // Whole run is a few hundred cycles
  initial begin
    tick(20000);
    error_cnt++;
    close_out();
  end
  initial begin
    {rst_i, wb_cyc_i, wb_stb_i, wb_we_i, serial_mem_enable_pin_i, cfg_word_valid_i} = 6'b100000;
    {tx_req_valid_i, switch_global_ctrl_three_fc_i, rx_fifo_thresh_i, rx_pause_valid_i} = 4'h0;
    {rx_hdr_valid_i, rx_end_i} = 2'b00;
    wb_adr_i = 8'h00; wb_sel_i = 4'h0; wb_dat_i = 32'h0; cfg_word_i = 16'h0000; lat = 8'h02;
    rx_pause_quanta_i = 16'h0000; station_addr_i = STA; tx_req_i = '0; rx_hdr_i = '0;
    error_cnt = 0; samples_checked = 0;
    tick(10);
    rst_i <= 1'b0;
    wb_rd(`HQMAC_ADR_TX_CTRL, 32'h0);
    wb_rd(`HQMAC_ADR_RX_CTRL, 32'h0);
    wb_rd(`HQMAC_ADR_BUS_CFG, 32'h0);
    wb_wr(`HQMAC_ADR_TX_STAT, 32'hFFFF);
    wb_rd(`HQMAC_ADR_TX_STAT, 32'h0);
    wb_wr(8'h3C, 32'hFFFF);
    wb_rd(8'h3C, 32'h0);
    wb_wr(`HQMAC_ADR_TX_CTRL, 32'hFFFF0000);
    wb_rd(`HQMAC_ADR_TX_CTRL, 32'h0);
    wb_wr(`HQMAC_ADR_RX_CTRL, 32'hFFFF);
    wb_rd(`HQMAC_ADR_RX_CTRL, 32'h06FD);
    // Serial memory configuration load
    cfg_word_i <= 16'h0001; cfg_word_valid_i <= 1'b1; tick(1); cfg_word_valid_i <= 1'b0;
    wb_rd(`HQMAC_ADR_BUS_CFG, 32'h0);
    serial_mem_enable_pin_i <= 1'b1; cfg_word_valid_i <= 1'b1; tick(1); cfg_word_valid_i <= 1'b0;
    wb_rd(`HQMAC_ADR_BUS_CFG, 32'h1);
    chk(host_bus_16bit_o, 1);
    cfg_word_i <= 16'hFFFE; cfg_word_valid_i <= 1'b1; tick(1); cfg_word_valid_i <= 1'b0;
    wb_rd(`HQMAC_ADR_BUS_CFG, 32'h0);
    chk(host_bus_16bit_o, 0);
    // Padding always goes with CRC append here
    wb_wr(`HQMAC_ADR_TX_CTRL, 32'h7);
    tx_send(6'h05, 11'd63, 8'hC5);
    wait_idle();
    wb_rd(`HQMAC_ADR_TX_STAT, 32'h05);
    lat <= 8'h28;
    tx_send(6'h2A, 11'd64, 8'h6A);
    wb_wr(`HQMAC_ADR_TX_CTRL, 32'h2);
    chk(tx_busy_o, 1);
    wait_idle();
    wb_rd(`HQMAC_ADR_TX_STAT, 32'h2A);
    tx_req_valid_i <= 1'b1; tick(2);
    chk(tx_req_ready_o, 0);
    tx_req_valid_i <= 1'b0;
    // Pause honour for one quantum of 128 cycles, then a four-quantum pause ignored with honour off
    wb_wr(`HQMAC_ADR_TX_CTRL, 32'h1);
    wb_wr(`HQMAC_ADR_RX_CTRL, 32'h400);
    pause_pulse(16'h0001); tick(3);
    chk({tx_paused_o, tx_req_ready_o}, 2'b10);
    tick(100);
    chk(tx_paused_o, 1);
    tick(40);
    chk({tx_paused_o, tx_req_ready_o}, 2'b01);
    wb_wr(`HQMAC_ADR_RX_CTRL, 32'h0);
    pause_pulse(16'h0004); tick(3);
    chk(tx_paused_o, 0);
    // Pause generation needs both enables and the threshold
    wb_wr(`HQMAC_ADR_TX_CTRL, 32'h8);
    rx_fifo_thresh_i <= 1'b1; tick(3);
    chk(pause_send_o, 0);
    switch_global_ctrl_three_fc_i <= 1'b1; tick(3);
    chk(pause_send_o, 1);
    rx_fifo_thresh_i <= 1'b0; tick(3);
    chk(pause_send_o, 0);
    // Receive filter cases
    rx_case(16'h0021, STA, 0, 0, 1);
    rx_case(16'h0021, OTH, 0, 0, 0);
    rx_case(16'h0081, BC, 0, 0, 1);
    rx_case(16'h0081, MC, 0, 0, 0);
    rx_case(16'h0041, BC, 0, 0, 1);
    rx_case(16'h0041, MC, 0, 0, 1);
    rx_case(16'h0005, MC, 0, 1, 1);
    rx_case(16'h0005, MC, 0, 0, 0);
    rx_case(16'h0011, OTH, 0, 0, 1);
    rx_case(16'h0011, OTH, 1, 0, 0);
    rx_case(16'h0211, OTH, 1, 0, 1);
    rx_case(16'h0001, STA, 0, 0, 0);
    rx_case(16'h0029, STA, 0, 0, 1);
    rx_case(16'h0020, STA, 0, 0, 0);
    // Clearing receive run mid-frame lets the frame finish
    wb_wr(`HQMAC_ADR_RX_CTRL, 32'h21);
    rx_hdr_valid_i <= 1'b1; rx_hdr_i <= '{dest: STA, crc_err: 1'b0, hash_hit: 1'b0};
    tick(1);
    rx_hdr_valid_i <= 1'b0;
    wb_wr(`HQMAC_ADR_RX_CTRL, 32'h0);
    chk(rx_busy_o, 1);
    rx_end_i <= 1'b1; tick(1); rx_end_i <= 1'b0; tick(2);
    chk(rx_busy_o, 0);
    close_out();
  end
endmodule
